// ### src/eqs_status_map.vh
// Constants and register layout for the event and quality status block.
// Summary of operation
// - Set event bit 0 when overlapped commands finish after an operation-complete request.
// - Event bit 1 always reads zero.
// - Query error sets event bit 2.
// - Device error sets event bit 3.
// - Execution error sets event bit 4.
// - Command syntax error sets event bit 5.
// - Power-on sets bit 7 until read/clear.
// - Clear status or event query clears flags.
// - Enable mask cleared at power-up or write 0.
// - Event summary when any enabled flag set.
// - Quality summary when any enabled bit set.
// - Measurement quality bit 3 set/cleared per measurement.
// - Calibration bit 8 follows zero/cal command result.
// - Self test bit 9 follows self test result.
// - Quality group 16 bits, bit 15 zero.
// - Summaries in status byte bits 3 and 5.
`ifndef EQS_STATUS_MAP_VH
`define EQS_STATUS_MAP_VH
`define EQS_EV_OPC      0
`define EQS_EV_UNUSED   1
`define EQS_EV_QUERY    2
`define EQS_EV_DEVICE   3
`define EQS_EV_EXEC     4
`define EQS_EV_CMD      5
`define EQS_EV_USER     6
`define EQS_EV_PWR      7
`define EQS_EV_RESET    8'h80
`define EQS_EV_VALID    8'hfd
`define EQS_QS_POWER    3
`define EQS_QS_CAL      8
`define EQS_QS_SELFTEST 9
`define EQS_QS_VALID    16'h0308
`define EQS_QS_RESET    16'h0000
`define EQS_EN_RESET    8'h00
`define EQS_QEN_RESET   16'h0000
`define EQS_SB_QUES     3
`define EQS_SB_EVENT    5
`endif

// ### src/eqs_opc_tracker.v
// Operation-complete tracker: counts outstanding overlapped commands.
module eqs_opc_tracker #(
	parameter CNT_W = 8
) (
	// Clock and reset.
	input  wire clk,
	input  wire rst_n,
	// Overlapped command events.
	input  wire ovl_start,
	input  wire ovl_done,
	input  wire opc_req,
	// Completion pulse.
	output reg  opc_done
);
	reg [CNT_W-1:0] pend_r;  // Overlapped commands still running.
	reg             armed_r; // A completion request is waiting.
	reg [CNT_W-1:0] pend_nxt;

	// Next count; a start and finish in the same cycle cancel out.
	always @* begin
		pend_nxt = pend_r;
		if (ovl_start && !ovl_done)
			pend_nxt = pend_r + {{(CNT_W-1){1'b0}}, 1'b1};
		else if (!ovl_start && ovl_done && pend_r != {CNT_W{1'b0}})
			pend_nxt = pend_r - {{(CNT_W-1){1'b0}}, 1'b1};
	end

	// Fire once when the request is armed and nothing is pending.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pend_r   <= {CNT_W{1'b0}};
			armed_r  <= 1'b0;
			opc_done <= 1'b0;
		end else begin
			pend_r   <= pend_nxt;
			opc_done <= 1'b0;
			if ((armed_r || opc_req) && pend_nxt == {CNT_W{1'b0}}) begin
				// Every command issued before the request has finished.
				armed_r  <= 1'b0;
				opc_done <= 1'b1;
			end else if (opc_req) begin
				armed_r <= 1'b1;
			end
		end
	end
endmodule // eqs_opc_tracker

// ### src/eqs_status_regs.v
// Standard event flags, their enable mask and the quality status group.
`include "eqs_status_map.vh"
module eqs_status_regs #(
	parameter OPC_CNT_W = 8
) (
	// Clock and asynchronous active-low reset.
	input  wire        clk,
	input  wire        rst_b,
	// Error and event sources, one-cycle pulses from instrument logic.
	input  wire        ovl_start,
	input  wire        ovl_done,
	input  wire        opc_cmd,
	input  wire        err_query,
	input  wire        err_device,
	input  wire        err_exec,
	input  wire        err_cmd,
	input  wire        user_req,
	// Common commands from the bus controller.
	input  wire        cls_cmd,
	input  wire        esr_query,
	input  wire        ese_write,
	input  wire [7:0]  ese_data,
	input  wire        qen_write,
	input  wire [15:0] qen_data,
	// Measurement quality reports.
	input  wire        meas_done,
	input  wire        meas_bad,
	input  wire        cal_done,
	input  wire        cal_err,
	input  wire        selftest_done,
	input  wire        selftest_fail,
	// Register views and summaries.
	output reg  [7:0]  esr_rdata,
	output reg  [7:0]  event_flags,
	output reg  [7:0]  event_enable,
	output reg  [15:0] ques_status,
	output reg  [15:0] ques_enable,
	output reg  [7:0]  stb_summary
);
	reg        rs1_r;    // Reset synchroniser first stage.
	reg        rst_n_r;  // Synchronised reset.
	wire       opc_pulse; // One-cycle completion event.
	reg  [7:0] ev_set;   // Bits raised by events this cycle.
	reg  [7:0] ev_nxt;
	reg [15:0] qs_nxt;
	reg [7:0]  ese_nxt;
	reg [15:0] qen_nxt;

	// Assertion is asynchronous, release is clocked through two stages.
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rs1_r   <= 1'b0;
			rst_n_r <= 1'b0;
		end else begin
			rs1_r   <= 1'b1;
			rst_n_r <= rs1_r;
		end
	end

	eqs_opc_tracker #(.CNT_W(OPC_CNT_W)) u_opc (
		.clk       (clk),
		.rst_n     (rst_n_r),
		.ovl_start (ovl_start),
		.ovl_done  (ovl_done),
		.opc_req   (opc_cmd),
		.opc_done  (opc_pulse)
	);

	// Collect the event sources into their flag positions.
	always @* begin
		ev_set                  = 8'h00;
		ev_set[`EQS_EV_OPC]     = opc_pulse;
		ev_set[`EQS_EV_QUERY]   = err_query;
		ev_set[`EQS_EV_DEVICE]  = err_device;
		ev_set[`EQS_EV_EXEC]    = err_exec;
		ev_set[`EQS_EV_CMD]     = err_cmd;
		ev_set[`EQS_EV_USER]    = user_req;
	end

	// Flags: clear on status clear or query, but a new event in the
	// same cycle survives so it is never lost.
	always @* begin
		ev_nxt = event_flags;
		if (cls_cmd || esr_query)
			ev_nxt = 8'h00;
		ev_nxt = (ev_nxt | ev_set) & `EQS_EV_VALID;
	end

	// Enable masks take what the host writes, with quality mask bit 15 forced to zero; a zero clears them.
	always @* begin
		ese_nxt = ese_write ? ese_data : event_enable;
		qen_nxt = qen_write ? (qen_data & 16'h7fff) : ques_enable;
	end

	// Quality bits are conditions, updated by each reporting activity.
	always @* begin
		qs_nxt = ques_status;
		if (meas_done)
			qs_nxt[`EQS_QS_POWER] = meas_bad;
		if (cal_done)
			qs_nxt[`EQS_QS_CAL] = cal_err;
		if (selftest_done)
			qs_nxt[`EQS_QS_SELFTEST] = selftest_fail;
		qs_nxt = qs_nxt & `EQS_QS_VALID;
	end

	// Register state and the registered outputs.
	always @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			event_flags  <= `EQS_EV_RESET;
			event_enable <= `EQS_EN_RESET;
			ques_status  <= `EQS_QS_RESET;
			ques_enable  <= `EQS_QEN_RESET;
			esr_rdata    <= 8'h00;
			stb_summary  <= 8'h00;
		end else begin
			event_flags  <= ev_nxt;
			event_enable <= ese_nxt;
			ques_status  <= qs_nxt;
			ques_enable  <= qen_nxt;
			// The query captures the flags before they are wiped.
			if (esr_query)
				esr_rdata <= event_flags | ev_set & `EQS_EV_VALID;
			// Summaries use next-state values so they track registers exactly.
			stb_summary <= 8'h00;
			stb_summary[`EQS_SB_QUES]  <= |(qs_nxt & qen_nxt);
			stb_summary[`EQS_SB_EVENT] <= |(ev_nxt & ese_nxt);
		end
	end
endmodule // eqs_status_regs

// ### bench/eqs_status_chk_sva.sv
// Assertion checker for the status register block.
module eqs_status_chk (
	input wire logic        clk, rst_b, err_query, err_device, err_exec, err_cmd, user_req,
	input wire logic        cls_cmd, esr_query, ese_write, meas_done, meas_bad, cal_done, cal_err,
	input wire logic [7:0]  ese_data, event_flags, event_enable, stb_summary,
	input wire logic [15:0] ques_status, ques_enable,
	input wire logic        selftest_done, selftest_fail
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	chk_unused_event: assert property (!event_flags[1]) else $error("bit 1 set");
	chk_exec_sets: assert property (err_exec |=> event_flags[4]) else $error("no exec");
	chk_clear_flags: assert property ((cls_cmd | esr_query) && !(err_query | err_device
		| err_exec | err_cmd | user_req) |=> event_flags[7:2] == 6'h00) else $error("no clear");
	chk_mask_load: assert property (ese_write |=> event_enable == $past(ese_data))
		else $error("mask");
	chk_event_sum: assert property (stb_summary[5] == |(event_flags & event_enable))
		else $error("ev sum");
	chk_ques_sum: assert property (stb_summary[3] == |(ques_status & ques_enable))
		else $error("q sum");
	chk_meas_bit: assert property (meas_done |=> ques_status[3] == $past(meas_bad))
		else $error("meas");
	chk_cal_bit: assert property (cal_done |=> ques_status[8] == $past(cal_err))
		else $error("cal");
	chk_unused_ques: assert property ((ques_status & 16'hfcf7) == 16'h0000)
		else $error("unused");
	chk_selftest_bit: assert property (selftest_done |=> ques_status[9] == $past(selftest_fail))
		else $error("selftest");
	chk_ques_top: assert property (!ques_enable[15] && !ques_status[15])
		else $error("bit 15 set");
	chk_stb_spare: assert property ((stb_summary & 8'hd7) == 8'h00)
		else $error("spare summary");
endmodule // eqs_status_chk
bind eqs_status_regs eqs_status_chk chk (.*);

// ### bench/eqs_host.sv
// Bus controller model that issues the common commands.
module eqs_host (
	input wire logic         clk,
	output logic             cls_cmd, esr_query, ese_write, qen_write,
	output logic [7:0]       ese_data,
	output logic [15:0]      qen_data
);
	timeunit 1ns;
	timeprecision 1ns;
	initial {cls_cmd, esr_query, ese_write, qen_write, ese_data, qen_data} = '0;
	// One-cycle command k: 0 clear, 1 query, 2 event mask, 3 quality mask.
	task cmd(input int k, input logic [15:0] d);
		@(negedge clk);
		ese_data = d[7:0];
		qen_data = d;
		{cls_cmd, esr_query, ese_write, qen_write} = 4'h8 >> k;
		@(negedge clk);
		{cls_cmd, esr_query, ese_write, qen_write} = 4'h0;
	endtask
endmodule // eqs_host

// ### bench/eqs_status_regs_test.sv
// Self-checking bench for the status register block.
`define CK(a, b) begin checks_done++; if ((a) !== (b)) begin mismatches++; \
	$display("ERROR %0t got %h exp %h", $time, a, b); end end
module eqs_status_regs_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 0, rst_b = 0, mb = 0, ce = 0, sf = 0, cl, eq, ew, qw;
	logic [10:0] src = '0;
	logic [7:0]  ed, rd, ef, ee, sb;
	logic [15:0] qd, qs, qe;
	int          mismatches = 0, checks_done = 0;
	always #4 clk = ~clk;
	eqs_host host (.clk(clk), .cls_cmd(cl), .esr_query(eq), .ese_write(ew), .qen_write(qw),
		.ese_data(ed), .qen_data(qd));
	eqs_status_regs dut (.clk(clk), .rst_b(rst_b), .ovl_start(src[7]), .ovl_done(src[1]),
		.opc_cmd(src[0]), .err_query(src[2]), .err_device(src[3]), .err_exec(src[4]),
		.err_cmd(src[5]), .user_req(src[6]), .cls_cmd(cl), .esr_query(eq), .ese_write(ew),
		.ese_data(ed), .qen_write(qw), .qen_data(qd), .meas_done(src[8]), .meas_bad(mb),
		.cal_done(src[9]), .cal_err(ce), .selftest_done(src[10]), .selftest_fail(sf),
		.esr_rdata(rd), .event_flags(ef), .event_enable(ee), .ques_status(qs),
		.ques_enable(qe), .stb_summary(sb));
	// Source pulses last one cycle, bits 2 to 6 of src line up with event bits 2 to 6.
	task p(input logic [10:0] v);
		@(negedge clk);
		src = v;
		@(negedge clk);
		src = '0;
	endtask
	task end_of_test;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (16) @(negedge clk);
		rst_b = 1;
		repeat (3) @(negedge clk);
		`CK(ee, 8'h00)
		host.cmd(1, 0);
		`CK(rd, 8'h80)
		`CK(ef, 8'h00)
		$display("reset test end");
		for (int i = 2; i < 7; i++) begin
			host.cmd(2, 16'h1 << i);
			p(11'h1 << i);
			`CK(ef, 8'h1 << i)
			`CK(sb, 8'h20)
			host.cmd(0, 0);
			`CK(ef, 8'h00)
		end
		host.cmd(2, 0);
		`CK(sb, 8'h00)
		$display("event test end");
		p(11'h080);
		p(11'h001);
		p(11'h000);
		`CK(ef[0], 1'b0)
		p(11'h002);
		@(negedge clk);
		`CK(ef, 8'h01)
		host.cmd(1, 0);
		`CK(rd, 8'h01)
		`CK(ef, 8'h00)
		$display("opc test end");
		host.cmd(3, 16'hffff);
		`CK(qe, 16'h7fff)
		{mb, ce, sf} = 3'h7;
		p(11'h700);
		`CK(qs, 16'h0308)
		`CK(sb, 8'h08)
		{mb, ce, sf} = 3'h0;
		p(11'h700);
		`CK(qs, 16'h0000)
		$display("quality test end");
		end_of_test;
	end
endmodule // eqs_status_regs_test
